// ==== shared/iex_pkg.sv ====
// Purpose: shared constants and carriers for the instruction subset block
// Assumes: 8-bit data, 7-bit file address, 5-bit special-page address
// Notes:   register offsets are APB byte addresses
package iex_pkg;

  localparam int DATA_W = 8;
  localparam int FADR_W = 7;
  localparam int SADR_W = 5;
  localparam int WDT_W  = 8;
  localparam int DIV_W  = 8;

  // apb register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_WORK   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WAKE   = 8'h0c;
  localparam logic [7:0] OFS_WDOG   = 8'h10;
  localparam logic [7:0] OFS_FILE   = 8'h14;
  localparam logic [7:0] OFS_SPEC   = 8'h18;

  // command register field layout
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OP_MSB   = 1;
  localparam int CMD_DEST_BIT = 2;
  localparam int CMD_ADR_LSB  = 8;
  localparam int CMD_ADR_MSB  = 14;

  // status register bit positions
  localparam int ST_ZERO  = 0;
  localparam int ST_HALF  = 1;
  localparam int ST_CARRY = 2;
  localparam int ST_EXP   = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_HALT  = 5;

  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [WDT_W-1:0]  WDT_CLR  = 8'h00;
  localparam logic [DIV_W-1:0]  DIV_CLR  = 8'h00;
  localparam logic              DEST_WORK = 1'b0;
  localparam logic              DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    OP_HALT,
    OP_SPECW,
    OP_SUBW,
    OP_NIBX
  } iex_op_t;

  typedef struct packed {
    iex_op_t             op;
    logic                dest;
    logic [FADR_W-1:0]   adr;
  } iex_cmd_t;

  typedef struct packed {
    logic zero;
    logic half;
    logic carry;
  } iex_flags_t;

endpackage

// ==== core/iex_alu.sv ====
// Purpose: data path for subtract and nibble exchange
// Assumes: purely combinational
// Notes:   carry is the not-borrow of the subtraction
`timescale 1ns/1ps
module iex_alu (
  input  wire logic [iex_pkg::DATA_W-1:0] regVal,
  input  wire logic [iex_pkg::DATA_W-1:0] workVal,
  input  wire logic                       doSub,
  output logic [iex_pkg::DATA_W-1:0]      result,
  output iex_pkg::iex_flags_t             flags
);
  logic [iex_pkg::DATA_W:0] diff;
  logic [4:0]               lowDiff;

  always_comb begin
    diff    = {1'b0, regVal} + {1'b0, ~workVal} + 9'h001;
    lowDiff = {1'b0, regVal[3:0]} + {1'b0, ~workVal[3:0]} + 5'h01;
    if (doSub) begin
      result = diff[7:0];
    end else begin
      result = {regVal[3:0], regVal[7:4]};
    end
    flags.zero  = (diff[7:0] == 8'h00);
    flags.half  = lowDiff[4];
    flags.carry = diff[8];
  end
endmodule

// ==== core/iex_watchdog.sv ====
// Purpose: watchdog divider and counter with synchronous clear
// Assumes: single clock, clock enable freezes state
// Notes:   clear wins over counting in the same cycle
`timescale 1ns/1ps
module iex_watchdog #(
  parameter int DIV_W = iex_pkg::DIV_W,
  parameter int WDT_W = iex_pkg::WDT_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             clear,
  output logic [DIV_W-1:0]      divVal,
  output logic [WDT_W-1:0]      cntVal
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divVal <= '0;
      cntVal <= '0;
    end else if (clkEn) begin
      if (clear) begin
        divVal <= DIV_W'(iex_pkg::DIV_CLR);
        cntVal <= WDT_W'(iex_pkg::WDT_CLR);
      end else begin
        divVal <= divVal + 1'b1;
        if (&divVal) begin
          cntVal <= cntVal + 1'b1;
        end
      end
    end
  end
endmodule

// ==== core/iex_core.sv ====
// Purpose: executes halt, special write, subtract and nibble exchange
// Assumes: APB slave, 32-bit data; file and special pages held locally
// Notes:   each command finishes in the write's own access cycle
//
// Behaviour
// - Halt entry clears the watchdog counter and its divider to zero.
// - Halt entry sets the expiry flag, clears the sleep flag, halts.
// - Special write copies the working register to page entry 0..31.
// - Subtract computes file register minus working register.
// - Subtract result goes to work on dest 0, to the file on dest 1.
// - Carry reads 0 on a borrow and 1 when no borrow occurred.
// - Nibble exchange swaps the low and high halves of the source.
// - Exchange result goes to work or file by dest, flags unchanged.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module iex_core #(
  parameter int FILE_DEPTH = 128,
  parameter int SPEC_DEPTH = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic         wakeEvent,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              halted
);
  localparam int DW = iex_pkg::DATA_W;

  logic [DW-1:0]             fileMem [FILE_DEPTH];
  logic [DW-1:0]             specMem [SPEC_DEPTH];
  logic [DW-1:0]             work_q;
  iex_pkg::iex_flags_t       flags_q;
  logic                      expiry_q;
  logic                      sleepEntry_q;
  logic                      halt_q;
  logic [iex_pkg::FADR_W-1:0] fileAdr_q;
  logic [iex_pkg::SADR_W-1:0] specAdr_q;
  logic [31:0]               rdata_q;

  iex_pkg::iex_cmd_t         cmd;
  iex_pkg::iex_flags_t       aluFlags;
  logic [DW-1:0]             aluResult;
  logic [DW-1:0]             regVal;
  logic                      wrAcc;
  logic                      rdAcc;
  logic                      execCmd;
  logic                      mapped;
  logic [iex_pkg::DIV_W-1:0] divVal;
  logic [iex_pkg::WDT_W-1:0] cntVal;
  logic                      wdtClear;
  logic                      doSub;

  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      iex_pkg::OFS_CMD,
      iex_pkg::OFS_WORK,
      iex_pkg::OFS_STATUS,
      iex_pkg::OFS_WAKE,
      iex_pkg::OFS_WDOG,
      iex_pkg::OFS_FILE,
      iex_pkg::OFS_SPEC: mapped = 1'b1;
      default:           mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // commands are refused while halted; only a wake or a reset releases the core
  assign execCmd = wrAcc && (paddr == iex_pkg::OFS_CMD) && !halt_q
                   && clkEn;

  always_comb begin
    cmd.op   = iex_pkg::iex_op_t'(
                 pwdata[iex_pkg::CMD_OP_MSB:iex_pkg::CMD_OP_LSB]);
    cmd.dest = pwdata[iex_pkg::CMD_DEST_BIT];
    cmd.adr  = pwdata[iex_pkg::CMD_ADR_MSB:iex_pkg::CMD_ADR_LSB];
  end

  assign regVal   = fileMem[cmd.adr];
  assign doSub    = (cmd.op == iex_pkg::OP_SUBW);
  assign wdtClear = execCmd && (cmd.op == iex_pkg::OP_HALT);

  iex_alu u_alu (
    .regVal  (regVal),
    .workVal (work_q),
    .doSub   (doSub),
    .result  (aluResult),
    .flags   (aluFlags)
  );

  iex_watchdog u_wdog (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .clear   (wdtClear),
    .divVal  (divVal),
    .cntVal  (cntVal)
  );

  // working register and flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_q  <= iex_pkg::WORK_RST;
      flags_q <= '0;
    end else if (clkEn) begin
      if (execCmd) begin
        case (cmd.op)
          iex_pkg::OP_SUBW: begin
            flags_q <= aluFlags;
            if (cmd.dest == iex_pkg::DEST_WORK) begin
              work_q <= aluResult;
            end
          end
          iex_pkg::OP_NIBX: begin
            // flags deliberately left alone
            if (cmd.dest == iex_pkg::DEST_WORK) begin
              work_q <= aluResult;
            end
          end
          default: begin
          end
        endcase
      end else if (wrAcc && paddr == iex_pkg::OFS_WORK) begin
        work_q <= pwdata[DW-1:0];
      end
    end
  end

  // file register page; software may preload entries
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      if (execCmd && cmd.dest == iex_pkg::DEST_FILE &&
          (cmd.op == iex_pkg::OP_SUBW || cmd.op == iex_pkg::OP_NIBX)) begin
        fileMem[cmd.adr] <= aluResult;
      end else if (wrAcc && paddr == iex_pkg::OFS_FILE) begin
        fileMem[fileAdr_q] <= pwdata[DW-1:0];
      end
    end
  end

  // special-function page, written only from the working register
  always_ff @(posedge sys_clk) begin
    if (clkEn && execCmd && cmd.op == iex_pkg::OP_SPECW) begin
      specMem[cmd.adr[iex_pkg::SADR_W-1:0]] <= work_q;
    end
  end

  // window pointers for the file and special pages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fileAdr_q <= '0;
      specAdr_q <= '0;
    end else if (clkEn && wrAcc && paddr == iex_pkg::OFS_WAKE) begin
      fileAdr_q <= pwdata[iex_pkg::CMD_ADR_MSB:iex_pkg::CMD_ADR_LSB];
      specAdr_q <= pwdata[iex_pkg::SADR_W-1:0];
    end
  end

  // power flags and halt state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expiry_q     <= 1'b1;
      sleepEntry_q <= 1'b1;
      halt_q       <= 1'b0;
    end else if (clkEn) begin
      if (wdtClear) begin
        expiry_q     <= 1'b1;
        sleepEntry_q <= 1'b0;
        halt_q       <= 1'b1;
      end else if (halt_q && wakeEvent) begin
        halt_q <= 1'b0;
      end
    end
  end

  assign halted = halt_q;

  // registered read data, valid in the access cycle of the same read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (clkEn && psel && !penable && !pwrite) begin
      case (paddr)
        iex_pkg::OFS_WORK:   rdata_q <= {24'h000000, work_q};
        iex_pkg::OFS_STATUS: begin
          rdata_q                     <= '0;
          rdata_q[iex_pkg::ST_ZERO]   <= flags_q.zero;
          rdata_q[iex_pkg::ST_HALF]   <= flags_q.half;
          rdata_q[iex_pkg::ST_CARRY]  <= flags_q.carry;
          rdata_q[iex_pkg::ST_EXP]    <= expiry_q;
          rdata_q[iex_pkg::ST_SLEEP]  <= sleepEntry_q;
          rdata_q[iex_pkg::ST_HALT]   <= halt_q;
        end
        iex_pkg::OFS_WAKE:   rdata_q <= {17'h00000, fileAdr_q,
                                          3'h0, specAdr_q};
        iex_pkg::OFS_WDOG:   rdata_q <= {16'h0000, cntVal, divVal};
        iex_pkg::OFS_FILE:   rdata_q <= {24'h000000, fileMem[fileAdr_q]};
        iex_pkg::OFS_SPEC:   rdata_q <= {24'h000000, specMem[specAdr_q]};
        default:             rdata_q <= '0;
      endcase
    end
  end

  // unmapped reads give zero even when the latch is stale from clkEn low
  assign prdata = (rdAcc && mapped) ? rdata_q : 32'h00000000;
endmodule

// ==== verif/iex_core_properties.sv ====
// Purpose: port checker for the instruction subset core
// Assumes: single clock, zero wait state apb slave
// Notes:   bound to every iex_core instance
`timescale 1ns/1ps
module iex_core_properties (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        wakeEvent,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halted
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic cmdW;
  assign acc = psel && penable;
  assign cmdW = acc && pwrite && clkEn && paddr == 8'h00;
  property p_halt;
    cmdW && pwdata[1:0] == 2'b00 && !halted && !wakeEvent |=> halted;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt command did not halt");
  property p_stay;
    halted && !(wakeEvent && clkEn) |=> halted;
  endproperty
  a_stay: assert property (p_stay)
    else $error("halt left without wake");
  property p_wake;
    halted && wakeEvent && clkEn |=> !halted;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not end halt");
  property p_stat;
    acc && !pwrite && paddr == 8'h08 && halted && $past(clkEn)
      |-> prdata[5:3] == 3'b101;
  endproperty
  a_stat: assert property (p_stat)
    else $error("halt status bits wrong");
  property p_rdy;
    acc |-> pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("access not done in one cycle");
  property p_quiet;
    !acc |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("read data outside access");
  property p_bad;
    acc && paddr > 8'h18 |-> pslverr && prdata == 32'h0;
  endproperty
  a_bad: assert property (p_bad)
    else $error("unmapped access not flagged");
  property p_hcmd;
    halted && cmdW && !wakeEvent |=> halted;
  endproperty
  a_hcmd: assert property (p_hcmd)
    else $error("command while halted took effect");
endmodule
bind iex_core iex_core_properties iex_core_properties_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
  .wakeEvent(wakeEvent), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halted(halted));

// ==== verif/iex_wake_src.sv ====
// Purpose: wake source standing beside the halted core
// Assumes: same clock domain as the core
// Notes:   one-cycle wake pulse, dly+1 clock edges after the edge that samples a request
`timescale 1ns/1ps
module iex_wake_src (
  input  wire logic       sys_clk,
  input  wire logic       req,
  input  wire logic [3:0] dly,
  output logic            wakeEvent
);
  int cnt = 0;
  initial wakeEvent = 1'b0;
  always @(posedge sys_clk) begin
    if (req) cnt <= int'(dly) + 1;
    else if (cnt > 0) cnt <= cnt - 1;
    wakeEvent <= cnt == 1 && !req;
  end
endmodule

// ==== verif/instr_exec_subset_tb.sv ====
// Purpose: self-checking bench for the instruction subset core
// Assumes: apb master tasks, integer reference model
// Notes:   the file page is preloaded through the pointer window
`timescale 1ns/1ps
module instr_exec_subset_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        wReq = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, halted, wakeEvent, err;
  int errors = 0, checked = 0;
  int z = 0, h = 0, c = 0, ex = 1, sl = 1, hl = 0;
  int a, r, w, d, op, res;
  iex_core iex_core_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .wakeEvent(wakeEvent), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halted(halted));
  iex_wake_src iex_wake_src_inst (.sys_clk(sys_clk), .req(wReq),
    .dly(4'h3), .wakeEvent(wakeEvent));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] dt);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= dt;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    cmp(rd, exp);
  endtask
  function automatic logic [31:0] stat();
    return 32'(hl * 32 + sl * 16 + ex * 8 + c * 4 + h * 2 + z);
  endfunction
  task automatic give_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(72));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(8'h08, stat());
    for (int i = 0; i < 40; i++) begin
      a = (i < 2) ? 127 * i : $urandom % 128;
      r = $urandom % 256;
      w = (i == 2) ? r : $urandom % 256;
      d = i % 2;
      op = (i < 20) ? 2 : 3;
      apb(1'b1, 8'h0c, 32'(a) << 8);
      apb(1'b1, 8'h14, 32'(r));
      apb(1'b1, 8'h04, 32'(w));
      apb(1'b1, 8'h00, 32'(a) << 8 | 32'(d) << 2 | 32'(op));
      if (op == 2) begin
        res = (r - w) & 255;
        z = res == 0;
        c = r >= w;
        h = (r % 16) >= (w % 16);
      end
      else res = (r % 16) * 16 + r / 16;
      rdchk(8'h04, 32'(d ? w : res));
      rdchk(8'h14, 32'(d ? res : r));
      rdchk(8'h08, stat());
    end
    for (int s = 0; s < 32; s += 31) begin
      w = $urandom % 256;
      apb(1'b1, 8'h04, 32'(w));
      apb(1'b1, 8'h00, 32'(s) << 8 | 32'h1);
      apb(1'b1, 8'h0c, 32'(s));
      rdchk(8'h18, 32'(w));
      rdchk(8'h08, stat());
    end
    // write with the clock enable low must be dropped
    clkEn <= 1'b0;
    apb(1'b1, 8'h04, 32'h5a);
    clkEn <= 1'b1;
    rdchk(8'h04, 32'(w));
    apb(1'b0, 8'h1c, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    ex = 1;
    sl = 0;
    hl = 1;
    // divider runs on after the clear, so only its high bits
    apb(1'b0, 8'h10, 32'h0);
    cmp({24'h0, rd[15:8]}, 32'h0);
    cmp({27'h0, rd[7:3]}, 32'h0);
    rdchk(8'h08, stat());
    cmp({31'h0, halted}, 32'h1);
    apb(1'b1, 8'h00, 32'h2);
    rdchk(8'h04, 32'(w));
    wReq <= 1'b1;
    @(posedge sys_clk);
    wReq <= 1'b0;
    repeat (8) @(posedge sys_clk);
    hl = 0;
    rdchk(8'h08, stat());
    cmp({31'h0, halted}, 32'h0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
endmodule
